// >>> pkg/cce_map.svh
// cce_map.svh
// Constants of the card command engine: opcodes, reply codes, timing.
// Definitions only; included by every design file of the engine.
`ifndef CCE_MAP_SVH
`define CCE_MAP_SVH

// ****************************************
// Command opcodes
// ****************************************
`define CCE_OP_AUTH_A  8'h60
`define CCE_OP_AUTH_B  8'h61
`define CCE_OP_READ    8'h30
`define CCE_OP_WRITE   8'ha0
`define CCE_OP_DEC     8'hc0
`define CCE_OP_INC     8'hc1
`define CCE_OP_RESTORE 8'hc2

// ****************************************
// Reply codes and frame lengths (CRC included except TOKEN, CHAL and BLOCK)
// ****************************************
`define CCE_ACK        4'ha
`define CCE_NAK        4'h4
`define CCE_LEN_CMD    5'h04
`define CCE_LEN_TOKEN  5'h08
`define CCE_LEN_OPND   5'h06
`define CCE_LEN_WDATA  5'h12
`define CCE_LEN_BUF    5'h12
`define CCE_LEN_CHAL   5'h04
`define CCE_LEN_BLOCK  5'h10

// ****************************************
// Frame check
// ****************************************
`define CCE_CRC_INIT   16'h6363
`define CCE_CRC_POLY   16'h8408
`define CCE_CRC_RESID  16'h0000

// ****************************************
// Timing and reset values
// ****************************************
`define CCE_CLK_MHZ    25
`define CCE_T_RSP_US   71
`define CCE_RSP_CYC    (`CCE_T_RSP_US * `CCE_CLK_MHZ)
`define CCE_CASC_FULL  2'h2
`define CCE_CASC_ONE   2'h1
`define CCE_TXW        10

`endif

// >>> pkg/cce_pkg.sv
// cce_pkg.sv
// Types of the card command engine: states and per-module state records.
// Widths follow cce_map.svh.
package cce_pkg;

   // Main sequencer, one-hot
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_EXEC  = 5'h02,
      ST_MEMW  = 5'h04,
      ST_AUTHW = 5'h08,
      ST_SEND  = 5'h10
   } cce_state_t;

   // Second part awaited, one-hot
   typedef enum logic [3:0] {
      PD_NONE  = 4'h1,
      PD_AUTH2 = 4'h2,
      PD_WR2   = 4'h4,
      PD_VAL2  = 4'h8
   } cce_pend_t;

   typedef struct packed {
      cce_state_t       st;
      cce_pend_t        pend;
      logic [17:0][7:0] frm;
      logic [4:0]       cnt;
      logic             ovf;
      logic [10:0]      dly;
      logic [10:0]      gap;
      logic [15:0][7:0] pay;
      logic [4:0]       plen;
      logic             pcrc;
      logic             pnib;
      logic [3:0]       nib;
      logic [4:0]       tidx;
      logic [7:0]       op;
      logic [7:0]       blk;
      logic             authed;
      logic             mem_req;
      logic             mem_we;
      logic [127:0]     wdata;
      logic             key_b;
      logic             tok_v;
      logic [63:0]      tok;
      logic [31:0]      val;
      logic [1:0]       casc;
      logic             strap_done;
   } cce_eng_t;

   typedef struct packed {
      logic        ov;
      logic [9:0]  od;
      logic        sv;
      logic [9:0]  sd;
   } cce_skid_t;

   typedef struct packed {
      logic [15:0] crc;
   } cce_crc_t;

endpackage : cce_pkg

// >>> testbench/cce_far.sv
// cce_far.sv: storage and cipher model facing the card engine.
// Assumes one storage request at a time, as the engine makes.
`timescale 1ns/100ps
module cce_far (
   // Clock
   input  logic         core_clk,
   // Storage
   input  logic         mem_req,
   input  logic         mem_we,
   input  logic [7:0]   mem_addr,
   input  logic [127:0] mem_wdata,
   output logic [127:0] mem_rdata,
   output logic         mem_ack,
   // Cipher
   input  logic         auth_tok_valid,
   output logic         auth_done,
   output logic         auth_pass,
   output logic [31:0]  auth_reply
);
   logic [127:0] blk_q [256];
   logic [1:0]   wt_q = 2'h0;
   logic [2:0]   cw_q = 3'h0;
   assign auth_pass  = 1'b1;
   assign auth_reply = 32'h5a3c9617;
   // Block n holds n in each byte; block 4 is value 100, address 4
   initial begin
      foreach (blk_q[i]) blk_q[i] = {16{i[7:0]}};
      blk_q[4] = {32'hfb04fb04, 32'h64, ~32'h64, 32'h64};
      mem_ack = 1'b0;
      auth_done = 1'b0;
      mem_rdata = '0;
   end
   // Slow on purpose; read data churns outside the answer
   always @(posedge core_clk) begin
      wt_q <= (mem_req && !mem_ack) ? wt_q + 2'h1 : 2'h0;
      mem_ack <= (wt_q == 2'h2);
      mem_rdata <= (wt_q == 2'h2) ? blk_q[mem_addr] : ~mem_rdata;
      if (wt_q == 2'h2 && mem_we) blk_q[mem_addr] <= mem_wdata;
      cw_q <= auth_tok_valid ? 3'h4 : (cw_q != 3'h0) ? cw_q - 3'h1 : 3'h0;
      auth_done <= (cw_q == 3'h1);
   end
endmodule : cce_far

// >>> testbench/tb_cce_engine.sv
// tb_cce_engine.sv: self-checking bench of the card command engine.
// Assumes cce_far answers the storage and cipher requests.
`timescale 1ns/100ps
`include "cce_map.svh"
module tb_cce_engine;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic rx_valid = 1'b0;
   logic rx_last = 1'b0;
   logic tx_ready = 1'b1;
   logic uid4_strap = 1'b0;
   logic [7:0] rx_data = 8'h00;
   logic [31:0] rng_word = 32'h44332211;
   logic tx_valid, tx_nibble, tx_last, mem_req, mem_we, mem_ack, authed;
   logic auth_key_b, auth_tok_valid, auth_done, auth_pass;
   logic [7:0] tx_data, mem_addr, auth_block;
   logic [127:0] mem_wdata, mem_rdata;
   logic [63:0] auth_tok;
   logic [31:0] auth_reply, value_reg;
   logic [1:0] casc_max;
   logic [9:0] rq[$];
   int n_fail = 0;
   int total_checks = 0;
   always #20 core_clk = ~core_clk;
   cce_engine dut (.*);
   cce_far far (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [15:0] crc_a(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'h6363;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
      end
      return c;
   endfunction : crc_a
   // Frame in at falling edges; bad flips one check bit
   task automatic send(input logic [7:0] f[$], input bit crc, input bit bad);
      logic [15:0] c;
      c = crc_a(f) ^ {15'h0, bad};
      if (crc) f = {f, c[7:0], c[15:8]};
      foreach (f[i]) begin
         @(negedge core_clk);
         rx_valid = 1'b1;
         rx_data = f[i];
         rx_last = (i == f.size() - 1);
      end
      @(negedge core_clk);
      rx_valid = 1'b0;
      rx_last = 1'b0;
   endtask : send
   // Stalls the transmitter half the time so the buffer backs up
   task automatic recv(input int n, input int lim, input bit stall);
      int t;
      int t0;
      t = 0;
      t0 = 0;
      rq = {};
      while (t < lim && !(n > 0 && rq.size() == n)) begin
         @(negedge core_clk);
         t++;
         tx_ready = !(stall && t[1]);
         if (tx_valid === 1'b1 && t0 == 0) t0 = t;
         if (tx_valid === 1'b1 && tx_ready) rq.push_back({tx_last, tx_nibble, tx_data});
      end
      chk(rq.size(), n);
      // First word is seen in the cycle it rises, so the bare timer length is legal
      if (n > 0) chk(t0 >= `CCE_RSP_CYC, 1);
   endtask : recv
   task automatic reply(input logic [7:0] b[$], input bit nib);
      logic [9:0] m;
      m = nib ? 10'h30f : 10'h3ff;
      recv(b.size(), 20000, !nib);
      foreach (b[i]) begin
         if (i < rq.size())
            chk(rq[i] & m, {i == b.size() - 1, nib, b[i]} & m);
      end
   endtask : reply
   task automatic t_unauth;
      chk(casc_max, 2);
      send('{`CCE_OP_READ, 8'h05}, 1, 0);
      reply('{`CCE_NAK}, 1);
      send('{`CCE_OP_AUTH_A, 8'h04}, 1, 1);
      recv(0, 2000, 0);
      $display("test refusals done");
   endtask : t_unauth
   task automatic t_auth;
      logic [7:0] tok[$] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
      // Short reader token: card stays silent, session stays closed
      send('{`CCE_OP_AUTH_A, 8'h04}, 1, 0);
      reply('{8'h11, 8'h22, 8'h33, 8'h44}, 0);
      send(tok[0:6], 0, 0);
      recv(0, 2000, 0);
      chk(authed, 0);
      for (int k = 0; k < 2; k++) begin
         send('{k ? `CCE_OP_AUTH_B : `CCE_OP_AUTH_A, 8'h04}, 1, 0);
         reply('{8'h11, 8'h22, 8'h33, 8'h44}, 0);
         chk({auth_key_b, auth_block}, {k[0], 8'h04});
         // Token stands for the reader's cipher keyed by its chosen identifier bytes
         send(tok, 0, 0);
         reply('{8'h17, 8'h96, 8'h3c, 8'h5a}, 0);
         chk(authed, 1);
         chk(auth_tok[31:0], 32'h04030201);
         chk(auth_tok[63:32], 32'h08070605);
      end
      $display("test auth done");
   endtask : t_auth
   function automatic void mk(output logic [7:0] d[$], input logic [7:0] v, s);
      d = {};
      for (int i = 0; i < 16; i++) d.push_back(v + s * i);
   endfunction : mk
   task automatic t_read(input logic [7:0] blk, v, s);
      logic [7:0] d[$];
      logic [15:0] c;
      mk(d, v, s);
      c = crc_a(d);
      send('{`CCE_OP_READ, blk}, 1, 0);
      reply({d, c[7:0], c[15:8]}, 0);
      $display("test read done");
   endtask : t_read
   task automatic t_write;
      logic [7:0] d[$];
      mk(d, 8'h90, 8'h01);
      send('{`CCE_OP_WRITE, 8'h06}, 1, 0);
      reply('{`CCE_ACK}, 1);
      send(d, 1, 0);
      reply('{`CCE_ACK}, 1);
      t_read(8'h06, 8'h90, 8'h01);
      $display("test write done");
   endtask : t_write
   task automatic t_value;
      logic [7:0] op [3] = '{`CCE_OP_INC, `CCE_OP_DEC, `CCE_OP_RESTORE};
      logic [31:0] ex [3] = '{32'd97, 32'd103, 32'd100};
      for (int k = 0; k < 3; k++) begin
         send('{op[k], 8'h04}, 1, 0);
         reply('{`CCE_ACK}, 1);
         send('{8'hfd, 8'hff, 8'hff, 8'hff}, 1, 0);
         recv(0, 2000, 0);
         chk(value_reg, ex[k]);
      end
      // Results stay volatile; only a transfer may change the source block
      chk(far.blk_q[4][31:0], 32'h00000064);
      send('{`CCE_OP_INC, 8'h05}, 1, 0);
      reply('{`CCE_NAK}, 1);
      $display("test value done");
   endtask : t_value
   // Mid-run reset as a four-byte identifier card
   task automatic t_strap;
      uid4_strap = 1'b1;
      rstn = 1'b0;
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      repeat (2) @(negedge core_clk);
      chk(casc_max, 1);
      $display("test strap done");
   endtask : t_strap
   task automatic print_verdict;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict
   // Fourteen reply waits of up to 20000 cycles and five silences of 2000, against a 60000-cycle limit
   initial begin
      #2400000;
      n_fail++;
      print_verdict;
   end
   // Main sequence, then a second reset as a four-byte card
   initial begin
      repeat (4) @(negedge core_clk);
      rstn = 1'b1;
      repeat (2) @(negedge core_clk);
      t_unauth;
      t_auth;
      t_read(8'h05, 8'h05, 8'h00);
      t_write;
      t_value;
      t_strap;
      print_verdict;
   end
endmodule : tb_cce_engine

// >>> verilog/cce_crc16.sv
// cce_crc16.sv
// Byte-serial frame check register, LSB first, reflected polynomial.
// Assumes clr and en are never needed in the same cycle; clr wins.
`timescale 1ns/100ps
`include "cce_map.svh"

module cce_crc16 #(
   parameter logic [15:0] INIT = `CCE_CRC_INIT
) (
   // Clock and reset
   input  logic        core_clk,
   input  logic        rstn,
   // Byte feed
   input  logic        clr,
   input  logic        en,
   input  logic [7:0]  din,
   // Running value
   output logic [15:0] crc_q
);

   cce_pkg::cce_crc_t q;
   cce_pkg::cce_crc_t d;

   // One byte per cycle, eight shifts unrolled by the loop
   always_comb begin
      d = q;
      if (clr) begin
         d.crc = INIT;
      end else if (en) begin
         for (int i = 0; i < 8; i++) begin
            if (d.crc[0] ^ din[i])
               d.crc = (d.crc >> 1) ^ `CCE_CRC_POLY;
            else
               d.crc = d.crc >> 1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         q.crc <= INIT;
      else
         q <= d;
   end

   assign crc_q = q.crc;

endmodule : cce_crc16

// >>> verilog/cce_engine.sv
// cce_engine.sv
// Card-side command interpreter: frame decode, reply timing, value ops.
// Assumes framed bytes from the radio layer, a block storage port and
// a cipher unit that checks the reader token and makes the card token.
`timescale 1ns/100ps
`include "cce_map.svh"

module cce_engine (
   // Clock and reset
   input  logic         core_clk,
   input  logic         rstn,
   // Reader frames, last marks the final data bit before closing bits
   input  logic         rx_valid,
   input  logic [7:0]   rx_data,
   input  logic         rx_last,
   // Card replies toward the transmitter
   output logic         tx_valid,
   input  logic         tx_ready,
   output logic [7:0]   tx_data,
   output logic         tx_nibble,
   output logic         tx_last,
   // Block storage
   output logic         mem_req,
   output logic         mem_we,
   output logic [7:0]   mem_addr,
   output logic [127:0] mem_wdata,
   input  logic [127:0] mem_rdata,
   input  logic         mem_ack,
   // Cipher unit
   input  logic [31:0]  rng_word,
   output logic         auth_key_b,
   output logic [7:0]   auth_block,
   output logic         auth_tok_valid,
   output logic [63:0]  auth_tok,
   input  logic         auth_done,
   input  logic         auth_pass,
   input  logic [31:0]  auth_reply,
   output logic         authed,
   // Volatile value and identity
   output logic [31:0]  value_reg,
   input  logic         uid4_strap,
   output logic [1:0]   casc_max
);

   localparam logic [10:0] DLY_LAST = 11'(`CCE_RSP_CYC - 1);

   cce_pkg::cce_eng_t q;
   cce_pkg::cce_eng_t d;

   logic [15:0] rx_crc;
   logic [15:0] tx_crc;
   logic        buf_ready;
   logic        acc;
   logic        push;
   logic        crc_ok;
   logic        cmd_go;
   logic        fmt_good;
   logic [4:0]  total;
   logic [9:0]  tx_word;
   logic [31:0] opnd;
   logic [31:0] srcv;

   // ****************************************
   // Value block layout check
   // ****************************************
   // Value, inverse, value, then address byte pattern a, ~a, a, ~a
   function automatic logic fmt_ok(input logic [15:0][7:0] b);
      logic [31:0] v;
      v = b[3:0];
      fmt_ok = (b[7:4] == ~v) && (b[11:8] == v) &&
               (b[13] == ~b[12]) && (b[14] == b[12]) && (b[15] == b[13]);
   endfunction : fmt_ok

   // ****************************************
   // Helpers
   // ****************************************
   // Bytes taken only while idle; a busy engine drops a stray frame
   assign acc      = rx_valid && (q.st == cce_pkg::ST_IDLE);
   assign crc_ok   = (rx_crc == `CCE_CRC_RESID) && !q.ovf;
   assign cmd_go   = (q.st == cce_pkg::ST_EXEC) && (q.pend != cce_pkg::PD_AUTH2) &&
                     crc_ok && (q.cnt == `CCE_LEN_CMD);
   assign fmt_good = fmt_ok(mem_rdata);
   assign total    = q.plen + (q.pcrc ? 5'h02 : 5'h00);
   assign opnd     = q.frm[3:0];
   assign srcv     = q.pay[3:0];
   // Nothing leaves before the least response time has run out
   assign push     = (q.st == cce_pkg::ST_SEND) && (q.dly == DLY_LAST) &&
                     buf_ready;

   // Reply word: {last, nibble flag, byte}
   always_comb begin
      tx_word = '0;
      if (q.pnib) begin
         tx_word = {1'b1, 1'b1, 4'h0, q.nib};
      end else begin
         if (q.tidx < q.plen)
            tx_word[7:0] = q.pay[q.tidx[3:0]];
         else if (q.tidx == q.plen)
            tx_word[7:0] = tx_crc[7:0];
         else
            tx_word[7:0] = tx_crc[15:8];
         tx_word[9] = (q.tidx == total - 5'h01);
      end
   end

   // ****************************************
   // Frame check and reply buffer
   // ****************************************
   cce_crc16 #(.INIT(`CCE_CRC_INIT)) u_rx_crc (
      .core_clk (core_clk),
      .rstn     (rstn),
      .clr      (q.st == cce_pkg::ST_EXEC),
      .en       (acc),
      .din      (rx_data),
      .crc_q    (rx_crc)
   );

   cce_crc16 #(.INIT(`CCE_CRC_INIT)) u_tx_crc (
      .core_clk (core_clk),
      .rstn     (rstn),
      .clr      (q.st == cce_pkg::ST_EXEC),
      .en       (push && !q.pnib && (q.tidx < q.plen)),
      .din      (tx_word[7:0]),
      .crc_q    (tx_crc)
   );

   // Transmitter stall holds the sequencer in SEND, no byte is lost
   cce_skid u_skid (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .in_valid  (push),
      .in_ready  (buf_ready),
      .in_data   (tx_word),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  ({tx_last, tx_nibble, tx_data})
   );

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      d       = q;
      d.tok_v = 1'b0;
      // Identity strap caught once after reset release
      if (!q.strap_done) begin
         d.strap_done = 1'b1;
         d.casc       = uid4_strap ? `CCE_CASC_ONE : `CCE_CASC_FULL;
      end
      // Response timer restarts at the last data bit of each frame taken in IDLE
      if (acc && rx_last)
         d.dly = 11'h000;
      else if (q.dly != DLY_LAST)
         d.dly = q.dly + 11'h001;
      // Independent gap count, read only by the checks below
      if (acc && rx_last)
         d.gap = 11'h000;
      else if (q.gap != 11'h7ff)
         d.gap = q.gap + 11'h001;
      unique case (q.st)
         cce_pkg::ST_IDLE: begin
            if (acc) begin
               if (q.cnt < `CCE_LEN_BUF)
                  d.frm[q.cnt] = rx_data;
               else
                  d.ovf = 1'b1;
               if (q.cnt != 5'h1f)
                  d.cnt = q.cnt + 5'h01;
               if (rx_last)
                  d.st = cce_pkg::ST_EXEC;
            end
         end
         cce_pkg::ST_EXEC: begin
            d.cnt  = 5'h00;
            d.ovf  = 1'b0;
            d.tidx = 5'h00;
            d.pnib = 1'b1;
            d.pcrc = 1'b0;
            d.nib  = `CCE_NAK;
            d.st   = cce_pkg::ST_SEND;
            if (q.pend == cce_pkg::PD_AUTH2) begin
               // Reader token is enciphered and carries no plain CRC
               d.pend = cce_pkg::PD_NONE;
               if (q.cnt == `CCE_LEN_TOKEN) begin
                  d.tok_v = 1'b1;
                  d.tok   = q.frm[7:0];
                  d.st    = cce_pkg::ST_AUTHW;
               end else begin
                  d.authed = 1'b0;
                  d.st     = cce_pkg::ST_IDLE;
               end
            end else if (!crc_ok) begin
               d.st = cce_pkg::ST_IDLE;
            end else if ((q.pend == cce_pkg::PD_WR2) && (q.cnt == `CCE_LEN_WDATA)) begin
               d.pend    = cce_pkg::PD_NONE;
               d.mem_req = 1'b1;
               d.mem_we  = 1'b1;
               d.wdata   = q.frm[15:0];
               d.st      = cce_pkg::ST_MEMW;
            end else if ((q.pend == cce_pkg::PD_VAL2) && (q.cnt == `CCE_LEN_OPND)) begin
               // Result stays volatile until the reader transfers it
               d.pend = cce_pkg::PD_NONE;
               d.st   = cce_pkg::ST_IDLE;
               if (q.op == `CCE_OP_INC)
                  d.val = srcv + opnd;
               else if (q.op == `CCE_OP_DEC)
                  d.val = srcv - opnd;
               else
                  d.val = srcv;
            end else if (q.cnt != `CCE_LEN_CMD) begin
               d.pend = cce_pkg::PD_NONE;
            end else begin
               d.pend = cce_pkg::PD_NONE;
               d.op   = q.frm[0];
               d.blk  = q.frm[1];
               if ((q.frm[0] == `CCE_OP_AUTH_A) || (q.frm[0] == `CCE_OP_AUTH_B)) begin
                  // New authentication drops the old session first
                  d.key_b     = q.frm[0][0];
                  d.authed    = 1'b0;
                  d.pay[3:0]  = rng_word;
                  d.plen      = `CCE_LEN_CHAL;
                  d.pnib      = 1'b0;
                  d.pend      = cce_pkg::PD_AUTH2;
               end else if (!q.authed) begin
                  d.nib = `CCE_NAK;
               end else if (q.frm[0] == `CCE_OP_WRITE) begin
                  d.nib  = `CCE_ACK;
                  d.pend = cce_pkg::PD_WR2;
               end else if ((q.frm[0] == `CCE_OP_READ) || (q.frm[0] == `CCE_OP_INC) ||
                            (q.frm[0] == `CCE_OP_DEC) || (q.frm[0] == `CCE_OP_RESTORE)) begin
                  d.mem_req = 1'b1;
                  d.mem_we  = 1'b0;
                  d.st      = cce_pkg::ST_MEMW;
               end
            end
         end
         cce_pkg::ST_MEMW: begin
            if (mem_ack) begin
               d.mem_req = 1'b0;
               d.st      = cce_pkg::ST_SEND;
               if (q.mem_we) begin
                  d.mem_we = 1'b0;
                  d.nib    = `CCE_ACK;
               end else if (q.op == `CCE_OP_READ) begin
                  d.pay  = mem_rdata;
                  d.plen = `CCE_LEN_BLOCK;
                  d.pcrc = 1'b1;
                  d.pnib = 1'b0;
               end else if (fmt_good) begin
                  d.pay  = mem_rdata;
                  d.nib  = `CCE_ACK;
                  d.pend = cce_pkg::PD_VAL2;
               end else begin
                  d.nib = `CCE_NAK;
               end
            end
         end
         cce_pkg::ST_AUTHW: begin
            if (auth_done) begin
               if (auth_pass) begin
                  d.authed   = 1'b1;
                  d.pay[3:0] = auth_reply;
                  d.plen     = `CCE_LEN_CHAL;
                  d.pnib     = 1'b0;
                  d.st       = cce_pkg::ST_SEND;
               end else begin
                  d.st = cce_pkg::ST_IDLE;
               end
            end
         end
         cce_pkg::ST_SEND: begin
            if (push) begin
               d.tidx = q.tidx + 5'h01;
               if (tx_word[9])
                  d.st = cce_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // State register; only constants under reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         q      <= '0;
         q.st   <= cce_pkg::ST_IDLE;
         q.pend <= cce_pkg::PD_NONE;
         q.dly  <= DLY_LAST;
         q.gap  <= 11'h7ff;
         q.nib  <= `CCE_NAK;
         q.casc <= `CCE_CASC_FULL;
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // Outputs, all from flip-flops
   // ****************************************
   assign mem_req        = q.mem_req;
   assign mem_we         = q.mem_we;
   assign mem_addr       = q.blk;
   assign mem_wdata      = q.wdata;
   assign auth_key_b     = q.key_b;
   assign auth_block     = q.blk;
   assign auth_tok_valid = q.tok_v;
   assign auth_tok       = q.tok;
   assign authed         = q.authed;
   assign value_reg      = q.val;
   assign casc_max       = q.casc;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   reply_wait_a: assert property (
      push |-> (q.gap >= 11'(`CCE_RSP_CYC - 1)))
      else $error("reply byte sent before least response time");

   auth_chal_a: assert property (
      cmd_go && ((q.frm[0] == `CCE_OP_AUTH_A) || (q.frm[0] == `CCE_OP_AUTH_B))
      |=> !q.pnib && (q.plen == `CCE_LEN_CHAL) && (q.pend == cce_pkg::PD_AUTH2) &&
          (q.pay[3:0] == $past(rng_word)))
      else $error("auth part one did not return a four byte challenge");

   crc_drop_a: assert property (
      (q.st == cce_pkg::ST_EXEC) && (q.pend != cce_pkg::PD_AUTH2) && !crc_ok
      |=> (q.st == cce_pkg::ST_IDLE) [*2])
      else $error("frame with bad CRC was acted upon");

   read_len_a: assert property (
      (q.st == cce_pkg::ST_MEMW) && mem_ack && !q.mem_we && (q.op == `CCE_OP_READ)
      |=> (q.plen == `CCE_LEN_BLOCK) && q.pcrc && (q.pay == $past(mem_rdata)))
      else $error("read reply not sixteen block bytes");

   wr_store_a: assert property (
      (q.st == cce_pkg::ST_EXEC) && (q.pend == cce_pkg::PD_WR2) && crc_ok &&
      (q.cnt == `CCE_LEN_WDATA)
      |=> mem_req && mem_we && (mem_wdata == $past(q.frm[15:0])))
      else $error("write part two data not stored");

   inc_val_a: assert property (
      (q.st == cce_pkg::ST_EXEC) && (q.pend == cce_pkg::PD_VAL2) && crc_ok &&
      (q.cnt == `CCE_LEN_OPND) && (q.op == `CCE_OP_INC)
      |=> value_reg == $past(srcv) + $past(opnd))
      else $error("increment result wrong");

   dec_val_a: assert property (
      (q.st == cce_pkg::ST_EXEC) && (q.pend == cce_pkg::PD_VAL2) && crc_ok &&
      (q.cnt == `CCE_LEN_OPND) && (q.op == `CCE_OP_DEC)
      |=> value_reg == $past(srcv) - $past(opnd))
      else $error("decrement result wrong");

   restore_val_a: assert property (
      (q.st == cce_pkg::ST_EXEC) && (q.pend == cce_pkg::PD_VAL2) && crc_ok &&
      (q.cnt == `CCE_LEN_OPND) && (q.op == `CCE_OP_RESTORE)
      |=> value_reg == $past(srcv))
      else $error("restore result wrong");

   fmt_nak_a: assert property (
      (q.st == cce_pkg::ST_MEMW) && mem_ack && !q.mem_we && (q.op != `CCE_OP_READ) &&
      !fmt_good
      |=> q.pnib && (q.nib == `CCE_NAK) && (q.pend == cce_pkg::PD_NONE))
      else $error("bad value block not refused");

   val_silent_a: assert property (
      (q.st == cce_pkg::ST_EXEC) && (q.pend == cce_pkg::PD_VAL2) && crc_ok &&
      (q.cnt == `CCE_LEN_OPND)
      |=> !push [*3])
      else $error("reply sent after value part two");

   wr_ack_a: assert property (
      cmd_go && q.authed && (q.frm[0] == `CCE_OP_WRITE)
      |=> q.pnib && (q.nib == 4'ha) && (q.pend == cce_pkg::PD_WR2))
      else $error("write part one not acknowledged with Ah");

   casc_lvl_a: assert property (
      $rose(q.strap_done)
      |-> (casc_max == ($past(uid4_strap) ? `CCE_CASC_ONE : `CCE_CASC_FULL)))
      else $error("cascade level does not follow identifier size");

   read_done_c: cover property (
      push && tx_word[9] && q.pcrc);
   auth_pass_c: cover property (
      (q.st == cce_pkg::ST_AUTHW) && auth_done && auth_pass);
   value_op_c: cover property (
      (q.st == cce_pkg::ST_EXEC) && (q.pend == cce_pkg::PD_VAL2) && crc_ok);

endmodule : cce_engine

// >>> verilog/cce_skid.sv
// cce_skid.sv
// Two-entry buffer between reply builder and radio transmitter.
// Assumes the transmitter may hold out_ready low for any time.
`timescale 1ns/100ps
`include "cce_map.svh"

module cce_skid (
   // Clock and reset
   input  logic                 core_clk,
   input  logic                 rstn,
   // Fill side
   input  logic                 in_valid,
   output logic                 in_ready,
   input  logic [`CCE_TXW-1:0]  in_data,
   // Drain side
   output logic                 out_valid,
   input  logic                 out_ready,
   output logic [`CCE_TXW-1:0]  out_data
);

   cce_pkg::cce_skid_t q;
   cce_pkg::cce_skid_t d;

   // Ready is registered, so the spare slot absorbs a late stall
   always_comb begin
      d = q;
      if (q.ov && out_ready) begin
         if (q.sv) begin
            d.od = q.sd;
            d.sv = 1'b0;
         end else begin
            d.ov = 1'b0;
         end
      end
      if (in_valid && !q.sv) begin
         if (!d.ov) begin
            d.ov = 1'b1;
            d.od = in_data;
         end else begin
            d.sv = 1'b1;
            d.sd = in_data;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         q <= '0;
      else
         q <= d;
   end

   assign in_ready  = !q.sv;
   assign out_valid = q.ov;
   assign out_data  = q.od;

endmodule : cce_skid
